//--- include/rsr_pkg.sv
// Constants for the rotate / subtract / literal-return execution datapath.
// Assumes one instruction request per issue pulse on the core clock.
package rsr_pkg;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int PC_W = 15;

    // Instruction select codes
    typedef enum logic [1:0] {
        RSR_OP_RETURN_WITH_LITERAL = 2'h0,
        RSR_OP_ROTATE_LEFT = 2'h1,
        RSR_OP_ROTATE_RIGHT = 2'h2,
        RSR_OP_SUBTRACT_FROM_LITERAL = 2'h3
    } rsr_op_e;

    // Destination select values
    localparam logic DEST_WORKING = 1'h0;
    localparam logic DEST_FILE = 1'h1;

    // Cycle counts per instruction
    localparam logic [1:0] RETURN_CYCLES = 2'h2;
    localparam logic [1:0] SINGLE_CYCLES = 2'h1;

    // Bit positions
    localparam int MSB = 7;
    localparam int NIB_MSB = 3;

    // Reset values
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [14:0] PC_RST = 15'h0000;
endpackage : rsr_pkg

//--- hdl/rsr_alu.sv
// Combinational arithmetic for the rotate and subtract instructions.
// Assumes operands are stable while the caller samples the outputs.
`timescale 1ns/1ps
module rsr_alu (
    input  wire logic [7:0] operand,
    input  wire logic [7:0] work_val,
    input  wire logic       carry_in,
    input  wire logic [1:0] op,
    output logic      [7:0] result,
    output logic            carry_out,
    output logic            nibble_carry_out,
    output logic            zero_out
);
    logic [8:0] diff;
    logic [4:0] low_diff;

    // Literal minus working register; bit 8 set means borrow
    always_comb begin
        diff = {1'b0, operand} - {1'b0, work_val};
        low_diff = {1'b0, operand[3:0]} - {1'b0, work_val[3:0]};
        result = diff[7:0];
        carry_out = ~diff[8];                        // RULE_08
        nibble_carry_out = ~low_diff[4];             // RULE_09
        zero_out = (diff[7:0] == 8'h00);             // RULE_09
        unique case (rsr_pkg::rsr_op_e'(op))
            rsr_pkg::RSR_OP_ROTATE_LEFT: begin
                result = {operand[6:0], carry_in};   // RULE_04
                carry_out = operand[rsr_pkg::MSB];   // RULE_04
            end
            rsr_pkg::RSR_OP_ROTATE_RIGHT: begin
                result = {carry_in, operand[7:1]};   // RULE_06
                carry_out = operand[0];              // RULE_06
            end
            rsr_pkg::RSR_OP_SUBTRACT_FROM_LITERAL: begin
                result = diff[7:0];                  // RULE_07
            end
            rsr_pkg::RSR_OP_RETURN_WITH_LITERAL: begin
                result = operand;                    // RULE_01
                carry_out = carry_in;                // RULE_03
            end
        endcase
    end
endmodule : rsr_alu

//--- hdl/rsr_exec.sv
// Execution datapath for literal return, rotates and subtract-from-literal.
// Assumes the decoder holds issue for one cycle and waits for done before
// issuing again; file data is read combinationally by the register file.
`timescale 1ns/1ps
// What this block does
// RULE_01: Literal return loads working register with literal
// RULE_02: Literal return pops stack into program counter
// RULE_03: Literal return: two cycles, flags untouched
// RULE_04: Rotate left through carry, carry only
// RULE_05: Destination bit picks working or file
// RULE_06: Rotate right through carry, carry only
// RULE_07: Working register becomes literal minus working
// RULE_08: Carry is inverted borrow; nibble borrow clears
// RULE_09: Zero on zero result; nibble carry otherwise set
// RULE_10: Rotates and subtract take one cycle
module rsr_exec (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        issue,
    input  wire logic [1:0]  op,
    input  wire logic [7:0]  literal,
    input  wire logic [6:0]  file_addr,
    input  wire logic        dest,
    input  wire logic [7:0]  file_rdata,
    input  wire logic [14:0] stack_top_entry,
    input  wire logic        carry_flag,
    output logic      [6:0]  file_raddr,
    output logic      [7:0]  work_reg,
    output logic             file_we,
    output logic      [6:0]  file_waddr,
    output logic      [7:0]  file_wdata,
    output logic             stack_pop,
    output logic             pc_load,
    output logic      [14:0] pc_value,
    output logic             flag_we_carry,
    output logic             flag_we_nibble,
    output logic             flag_we_zero,
    output logic             carry_out,
    output logic             nibble_carry_flag,
    output logic             zero_out,
    output logic             busy,
    output logic             done
);
    typedef enum logic [0:0] {
        RSR_IDLE = 1'h0,
        RSR_RET2 = 1'h1
    } rsr_state_e;

    rsr_state_e  state, next_state;
    logic [7:0]  next_work_reg, next_file_wdata;
    logic [6:0]  next_file_waddr;
    logic [14:0] next_pc_value;
    logic        next_file_we, next_stack_pop, next_pc_load;
    logic        next_we_c, next_we_dc, next_we_z;
    logic        next_c, next_dc, next_z, next_done;
    logic [7:0]  alu_operand, alu_result;
    logic        alu_c, alu_dc, alu_z;
    logic        is_rot, is_sub, is_ret;

    // Rotates read the file register; others use the literal
    assign file_raddr = file_addr;                       // RULE_05
    assign is_rot = (op == 2'(rsr_pkg::RSR_OP_ROTATE_LEFT))
                 || (op == 2'(rsr_pkg::RSR_OP_ROTATE_RIGHT));
    assign is_sub = (op == 2'(rsr_pkg::RSR_OP_SUBTRACT_FROM_LITERAL));
    assign is_ret = (op == 2'(rsr_pkg::RSR_OP_RETURN_WITH_LITERAL));
    assign alu_operand = is_rot ? file_rdata : literal;
    assign busy = (state == RSR_RET2);

    rsr_alu u_alu (
        .operand          (alu_operand),
        .work_val         (work_reg),
        .carry_in         (carry_flag),
        .op               (op),
        .result           (alu_result),
        .carry_out        (alu_c),
        .nibble_carry_out (alu_dc),
        .zero_out         (alu_z)
    );

    // Next-state and result computation; strobes default to one-cycle pulses
    always_comb begin
        next_state = state;
        next_work_reg = work_reg;
        next_file_wdata = file_wdata;
        next_file_waddr = file_waddr;
        next_pc_value = pc_value;
        next_file_we = 1'b0;
        next_stack_pop = 1'b0;
        next_pc_load = 1'b0;
        next_we_c = 1'b0;
        next_we_dc = 1'b0;
        next_we_z = 1'b0;
        next_c = carry_out;
        next_dc = nibble_carry_flag;
        next_z = zero_out;
        next_done = 1'b0;
        unique case (state)
            RSR_IDLE: begin
                if (issue && is_ret) begin
                    next_work_reg = alu_result;          // RULE_01
                    next_stack_pop = 1'b1;               // RULE_02
                    next_pc_value = stack_top_entry;     // RULE_02
                    next_pc_load = 1'b1;                 // RULE_02
                    next_state = RSR_RET2;               // RULE_03
                end else if (issue && is_rot) begin
                    if (dest == rsr_pkg::DEST_FILE) begin
                        next_file_we = 1'b1;             // RULE_05
                        next_file_waddr = file_addr;
                        next_file_wdata = alu_result;
                    end else begin
                        next_work_reg = alu_result;      // RULE_05
                    end
                    next_we_c = 1'b1;                    // RULE_04
                    next_c = alu_c;
                    next_done = 1'b1;                    // RULE_10
                end else if (issue && is_sub) begin
                    next_work_reg = alu_result;          // RULE_07
                    next_we_c = 1'b1;                    // RULE_08
                    next_we_dc = 1'b1;                   // RULE_08
                    next_we_z = 1'b1;                    // RULE_09
                    next_c = alu_c;
                    next_dc = alu_dc;
                    next_z = alu_z;
                    next_done = 1'b1;                    // RULE_10
                end
            end
            RSR_RET2: begin
                // Second cycle flushes the fetch; issue is ignored here
                next_done = 1'b1;                        // RULE_03
                next_state = RSR_IDLE;
            end
        endcase
    end

    // Register stage; flag strobes never fire for literal return
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= RSR_IDLE;
            work_reg <= rsr_pkg::DATA_RST;
            file_wdata <= rsr_pkg::DATA_RST;
            file_waddr <= 7'h00;
            pc_value <= rsr_pkg::PC_RST;
            file_we <= 1'b0;
            stack_pop <= 1'b0;
            pc_load <= 1'b0;
            flag_we_carry <= 1'b0;
            flag_we_nibble <= 1'b0;
            flag_we_zero <= 1'b0;
            carry_out <= 1'b0;
            nibble_carry_flag <= 1'b0;
            zero_out <= 1'b0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            work_reg <= next_work_reg;
            file_wdata <= next_file_wdata;
            file_waddr <= next_file_waddr;
            pc_value <= next_pc_value;
            file_we <= next_file_we;
            stack_pop <= next_stack_pop;
            pc_load <= next_pc_load;
            flag_we_carry <= next_we_c;
            flag_we_nibble <= next_we_dc;
            flag_we_zero <= next_we_z;
            carry_out <= next_c;
            nibble_carry_flag <= next_dc;
            zero_out <= next_z;
            done <= next_done;
        end
    end
endmodule : rsr_exec

//--- sim/rsr_partner.sv
// Register file, return stack and carry flag beside the datapath.
// Assumes the bench presets contents before reset is released.
`timescale 1ns/1ps
module rsr_partner (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [6:0]  file_raddr,
    input  wire logic        file_we,
    input  wire logic [6:0]  file_waddr,
    input  wire logic [7:0]  file_wdata,
    input  wire logic        stack_pop,
    input  wire logic        flag_we_carry,
    input  wire logic        carry_out,
    output logic      [7:0]  file_rdata,
    output logic      [14:0] stack_top_entry,
    output logic             carry_flag
);
    logic [7:0]  mem [128];
    logic [14:0] stk [4];
    logic [1:0]  sp;
    // Reads are combinational; the datapath samples them at issue
    assign file_rdata      = mem[file_raddr];
    assign stack_top_entry = stk[sp];
    // Strobes land on the edge after they appear, so no forwarding
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sp <= 2'h0;
        end else begin
            if (file_we) mem[file_waddr] <= file_wdata;
            if (flag_we_carry) carry_flag <= carry_out;
            if (stack_pop) sp <= sp + 2'h1;
        end
    end
endmodule : rsr_partner

//--- sim/rsr_exec_checker.sv
// Port assertions for the execution datapath.
// Assumes a bind to rsr_exec; one clock, nrst active low.
`timescale 1ns/1ps
module rsr_exec_checker (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        issue,
    input wire logic [1:0]  op,
    input wire logic [7:0]  literal,
    input wire logic        dest,
    input wire logic [7:0]  file_rdata,
    input wire logic [14:0] stack_top_entry,
    input wire logic        carry_flag,
    input wire logic [7:0]  work_reg,
    input wire logic        file_we,
    input wire logic [7:0]  file_wdata,
    input wire logic        stack_pop,
    input wire logic [14:0] pc_value,
    input wire logic        flag_we_carry,
    input wire logic        flag_we_zero,
    input wire logic        carry_out,
    input wire logic        nibble_carry_flag,
    input wire logic        zero_out,
    input wire logic        busy,
    input wire logic        done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Accepted requests per kind; busy blocks acceptance
    sequence s_ret; issue && !busy && op == 2'h0; endsequence
    sequence s_one; issue && !busy && op != 2'h0; endsequence
    sequence s_ret_steps;
        busy && !done && !flag_we_carry ##1 done && !busy && !flag_we_zero;
    endsequence
    a_ret_work: assert property (s_ret |=> work_reg == $past(literal))
        else $error("return literal missing");
    a_ret_pop: assert property (s_ret |=> stack_pop &&
        pc_value == $past(stack_top_entry)) else $error("pop wrong");
    a_ret_two: assert property (s_ret |=> s_ret_steps)
        else $error("return timing or flags wrong");
    a_rot_left: assert property (s_one and (op == 2'h1) |=>
        {carry_out, ($past(dest) ? file_wdata : work_reg)} ==
        {$past(file_rdata), $past(carry_flag)} && !flag_we_zero)
        else $error("rotate left wrong");
    a_rot_dest: assert property (s_one and (op[0] != op[1]) |=>
        file_we == $past(dest) && flag_we_carry) else $error("dest wrong");
    a_rot_right: assert property (s_one and (op == 2'h2) |=>
        {($past(dest) ? file_wdata : work_reg), carry_out} ==
        {$past(carry_flag), $past(file_rdata)}) else $error("rotate right");
    a_sub_math: assert property (s_one and (op == 2'h3) |=>
        work_reg == $past(literal) - $past(work_reg) &&
        zero_out == (work_reg == 8'h00)) else $error("subtract wrong");
    a_sub_flags: assert property (s_one and (op == 2'h3) |=>
        carry_out == ($past(work_reg) <= $past(literal)) &&
        nibble_carry_flag == ($past(work_reg[3:0]) <= $past(literal[3:0])))
        else $error("subtract flags wrong");
    a_one_cycle: assert property (s_one |=> done && !busy)
        else $error("single cycle not done");
endmodule : rsr_exec_checker

//--- sim/test_rotate_subtract_return_exec.sv
// Self-checking bench for the execution datapath.
// Assumes rsr_partner stands in for register file, stack and carry.
`timescale 1ns/1ps
module test_rotate_subtract_return_exec;
    logic        clk, nrst, issue, dest, carry_flag, file_we, stack_pop;
    logic        pc_load, flag_we_carry, flag_we_nibble, flag_we_zero;
    logic        carry_out, nibble_carry_flag, zero_out, busy, done;
    logic [1:0]  op;
    logic [6:0]  file_addr, file_raddr, file_waddr;
    logic [7:0]  literal, file_rdata, work_reg, file_wdata;
    logic [14:0] stack_top_entry, pc_value;
    logic [7:0]  wv [3] = '{8'h13, 8'h0f, 8'h00};
    logic [7:0]  kv [3] = '{8'h12, 8'h10, 8'hff};
    int          fails, n_checks;
    rsr_exec i_rsr_exec (.clk, .nrst, .issue, .op, .literal, .file_addr,
        .dest, .file_rdata, .stack_top_entry, .carry_flag, .file_raddr,
        .work_reg, .file_we, .file_waddr, .file_wdata, .stack_pop, .pc_load,
        .pc_value, .flag_we_carry, .flag_we_nibble, .flag_we_zero,
        .carry_out, .nibble_carry_flag, .zero_out, .busy, .done);
    rsr_partner i_rsr_partner (.clk, .nrst, .file_raddr, .file_we,
        .file_waddr, .file_wdata, .stack_pop, .flag_we_carry, .carry_out,
        .file_rdata, .stack_top_entry, .carry_flag);
    // Clock and a watchdog against a hung sequence
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (2000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    // Issue stays high on exit so back-to-back requests need no gap
    task automatic go(input logic [1:0] o, input logic [7:0] k,
                      input logic [6:0] a, input logic d);
        {issue, op, literal, file_addr, dest} = {1'b1, o, k, a, d};
        @(negedge clk);
    endtask : go
    task automatic idle();
        issue = 1'b0;
        @(negedge clk);
    endtask : idle
    task automatic t_ret();
        go(2'h0, 8'hff, 7'h00, 1'b0);
        chk(16'(work_reg), 16'h00ff);
        chk({stack_pop, pc_value}, 16'hfabc);
        chk(16'({busy, done, pc_load}), 16'h0005);
        go(2'h3, 8'h00, 7'h00, 1'b0);
        chk(16'({done, busy, flag_we_carry, flag_we_nibble}), 16'h8);
        idle();
        chk(16'(work_reg), 16'h00ff);
        $display("return test ended");
    endtask : t_ret
    task automatic t_rot();
        go(2'h1, 8'h00, 7'h05, 1'b0);
        chk(16'({work_reg, carry_out, flag_we_carry, file_we}), 16'h666);
        go(2'h3, 8'hcc, 7'h00, 1'b0);
        chk(16'({work_reg, carry_out, nibble_carry_flag, zero_out, done}),
            16'h0f);
        idle();
        go(2'h2, 8'h00, 7'h7f, 1'b1);
        chk({file_we, file_waddr, file_wdata}, 16'hff80);
        chk(16'({carry_out, work_reg, done}), 16'h201);
        idle();
        $display("rotate test ended");
    endtask : t_rot
    // Expected flags computed here from operands, not from the design
    task automatic t_sub();
        for (int i = 0; i < 3; i++) begin
            go(2'h0, wv[i], 7'h00, 1'b0);
            idle();
            go(2'h3, kv[i], 7'h00, 1'b0);
            chk(16'({work_reg, carry_out, nibble_carry_flag, zero_out}),
                16'({kv[i] - wv[i], wv[i] <= kv[i],
                wv[i][3:0] <= kv[i][3:0], kv[i] == wv[i]}));
            idle();
        end
        $display("subtract test ended");
    endtask : t_sub
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    initial begin
        {nrst, issue, op, literal, file_addr, dest} = '0;
        i_rsr_partner.stk = '{15'h7abc, 15'h0123, 15'h4567, 15'h1111};
        i_rsr_partner.mem[5] = 8'he6;
        i_rsr_partner.mem[127] = 8'h01;
        i_rsr_partner.carry_flag = 1'b0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        t_ret();
        t_rot();
        t_sub();
        tally_and_finish();
    end
endmodule : test_rotate_subtract_return_exec
bind rsr_exec rsr_exec_checker i_rsr_exec_checker (.clk, .nrst, .issue,
    .op, .literal, .dest, .file_rdata, .stack_top_entry, .carry_flag,
    .work_reg, .file_we, .file_wdata, .stack_pop, .pc_value, .flag_we_carry,
    .flag_we_zero, .carry_out, .nibble_carry_flag, .zero_out, .busy, .done);
